/* File: rtl/arith_cfg.svh */
`ifndef ARITH_CFG_SVH
`define ARITH_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// register byte offsets (haddr bits that are decoded)
`define ADDR_BITS        8
`define OFS_OPA          8'h00
`define OFS_OPA_HI       8'h04
`define OFS_OPB          8'h08
`define OFS_CMD          8'h0c
`define OFS_RES_LO       8'h10
`define OFS_RES_HI       8'h14
`define OFS_FLAGS        8'h18
`define OFS_IRQ_STAT     8'h1c
`define OFS_IRQ_CLR      8'h20
`define OFS_IRQ_EN       8'h24

////////////////////////////////////////////////////////////////////////////////
// command register fields
`define CMD_OP_LO        0
`define CMD_OP_HI        2
`define CMD_EN_BIT       3
`define CMD_IDX_BIT      4

// operation codes
`define OP_ADC           3'h0
`define OP_SBB           3'h1
`define OP_MUL           3'h2
`define OP_DIV16         3'h3
`define OP_DIV32         3'h4
`define OP_CLRC          3'h5

////////////////////////////////////////////////////////////////////////////////
// flags register fields
`define FLG_CARRY_BIT    0
`define FLG_ERR_BIT      1
`define FLG_OUT_BIT      2
`define FLG_BUSY_BIT     3

// interrupt status, clear and enable fields
`define IRQ_DONE_BIT     0
`define IRQ_ERR_BIT      1
`define IRQ_OVF_BIT      2
`define IRQ_BITS         3

// ahb encodings
`define HTRANS_NONSEQ_BIT 1

`endif

/* File: rtl/arith_pkg.sv */
package arith_pkg;
	typedef logic [2:0] op_t;
	typedef enum logic [0:0] {st_idle, st_div} unit_state_e;
endpackage

/* File: rtl/carry_adder.sv */
`include "arith_cfg.svh"

// add or subtract with carry in; reports carry or borrow and signed overflow
module carry_adder
	import arith_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic [W-1:0] a,
	input  wire logic [W-1:0] b,
	input  wire logic         cin,
	input  wire logic         sub,
	output logic      [W-1:0] sum,
	output logic              cout,
	output logic              ovf
);
	logic [W:0] uns;
	logic [W:0] sgn;

	// unsigned form gives carry or borrow, sign-extended form gives overflow
	always_comb begin
		if (sub) begin
			uns = {1'b0, a} - {1'b0, b} - {{W{1'b0}}, cin};
			sgn = {a[W-1], a} - {b[W-1], b} - {{W{1'b0}}, cin};
		end else begin
			uns = {1'b0, a} + {1'b0, b} + {{W{1'b0}}, cin};
			sgn = {a[W-1], a} + {b[W-1], b} + {{W{1'b0}}, cin};
		end
		sum  = uns[W-1:0];
		cout = uns[W];
		ovf  = sgn[W] ^ sgn[W-1];
	end
endmodule

/* File: rtl/carry_arith_unit.sv */
// Notes on behaviour
// [RL1] add: result is a plus b plus carry
// [RL2] add sets carry on carry out, else clears
// [RL3] add/sub output on at signed overflow
// [RL4] carry chains low word then high word
// [RL5] sub: result is a minus b minus carry
// [RL6] sub sets carry on borrow, else clears
// [RL7] carry clear command zeroes carry flag
// [RL8] unsigned multiply, 32-bit product, output on
// [RL9] upper half high register, lower half base
// [RL10] 16-bit divide: quotient, remainder, output on
// [RL11] zero divisor: nothing stored, output off, error
// [RL12] error flag sticky until software clears it
// [RL13] index destination drops the remainder; quotient overflow still zeroes res_hi_r
// [RL14] 32/16 divide from register pair
// [RL15] quotient overflow saturates, error, output on
// [RL16] enable off: nothing changes, output off
// [RL17] single shared carry and error bits, readable
//
// The implementer's own choices: the register addresses and the AHB-Lite interface to the registers.
`include "arith_cfg.svh"

module carry_arith_unit
	import arith_pkg::*;
#(
	parameter int DW = 16
) (
	input  wire logic                  mclk,
	input  wire logic                  rst,
	input  wire logic                  hsel,
	input  wire logic [31:0]           haddr,
	input  wire logic [1:0]            htrans,
	input  wire logic                  hwrite,
	input  wire logic [2:0]            hsize,
	input  wire logic [31:0]           hwdata,
	input  wire logic                  hready,
	output logic                       hreadyout,
	output logic                       hresp,
	output logic      [31:0]           hrdata,
	output logic                       irq
);
	localparam int AW = `ADDR_BITS;

	logic [AW-1:0]        wr_addr_r;
	logic                 wr_pend_r;
	logic                 hreadyout_r;
	logic                 hresp_r;
	logic [31:0]          hrdata_r;
	logic [31:0]          rd_val;
	logic                 rd_take;

	logic [DW-1:0]        opa_r;
	logic [DW-1:0]        opa_hi_r;
	logic [DW-1:0]        opb_r;
	logic [DW-1:0]        res_lo_r;
	logic [DW-1:0]        res_hi_r;
	logic [7:0]           cmd_r;
	logic                 carry_flag;
	logic                 instr_error_flag;
	logic                 out_r;
	logic                 idx_r;
	unit_state_e          state_r;

	logic [`IRQ_BITS-1:0] irq_stat_r;
	logic [`IRQ_BITS-1:0] irq_en_r;
	logic                 irq_r;

	logic                 wr_fire;
	logic                 cmd_go;
	op_t                  cmd_op;
	logic                 cmd_en;
	logic                 cmd_idx;
	logic                 do_add;
	logic                 do_sub;
	logic                 do_mul;
	logic                 do_clrc;
	logic                 do_off;
	logic                 do_bad;
	logic                 div_zero;
	logic                 div_sat;
	logic                 div_start;
	logic [2*DW-1:0]      div_dvd;
	logic                 err_clr;
	logic [`IRQ_BITS-1:0] ev;
	logic [`IRQ_BITS-1:0] irq_clr;

	logic [DW-1:0]        as_sum;
	logic                 as_cout;
	logic                 as_ovf;
	logic [2*DW-1:0]      product;
	logic                 dv_done;
	logic [DW-1:0]        dv_quot;
	logic [DW-1:0]        dv_rem;

	////////////////////////////////////////////////////////////////////////////
	// ahb-lite slave, always zero wait state, always okay

	// capture address phase of a write for use in the data phase
	always_ff @(posedge mclk) begin
		if (rst) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= '0;
		end else if (hready) begin
			wr_pend_r <= hsel & htrans[`HTRANS_NONSEQ_BIT] & hwrite;
			wr_addr_r <= haddr[AW-1:0];
		end
	end

	// handshake outputs held as flops
	always_ff @(posedge mclk) begin
		if (rst) begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end else begin
			hreadyout_r <= 1'b1;
			hresp_r     <= 1'b0;
		end
	end

	assign rd_take = hready & hsel & htrans[`HTRANS_NONSEQ_BIT] & ~hwrite;

	// read mux, unmapped and write-only offsets read zero
	always_comb begin
		rd_val = '0;
		unique case (haddr[AW-1:0])
			`OFS_OPA:      rd_val[DW-1:0] = opa_r;
			`OFS_OPA_HI:   rd_val[DW-1:0] = opa_hi_r;
			`OFS_OPB:      rd_val[DW-1:0] = opb_r;
			`OFS_CMD:      rd_val[7:0]    = cmd_r;
			`OFS_RES_LO:   rd_val[DW-1:0] = res_lo_r;
			`OFS_RES_HI:   rd_val[DW-1:0] = res_hi_r;
			`OFS_FLAGS: begin
				rd_val[`FLG_CARRY_BIT] = carry_flag; // RL17
				rd_val[`FLG_ERR_BIT]   = instr_error_flag; // RL17
				rd_val[`FLG_OUT_BIT]   = out_r;
				rd_val[`FLG_BUSY_BIT]  = state_r == st_div;
			end
			`OFS_IRQ_STAT: rd_val[`IRQ_BITS-1:0] = irq_stat_r;
			`OFS_IRQ_EN:   rd_val[`IRQ_BITS-1:0] = irq_en_r;
			default:       rd_val = '0;
		endcase
	end

	// read data registered at the address phase edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			hrdata_r <= '0;
		end else if (rd_take) begin
			hrdata_r <= rd_val;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// command decode

	assign wr_fire = wr_pend_r;
	assign cmd_go  = wr_fire && wr_addr_r == `OFS_CMD && state_r == st_idle;
	assign cmd_op  = hwdata[`CMD_OP_HI:`CMD_OP_LO];
	assign cmd_en  = hwdata[`CMD_EN_BIT];
	assign cmd_idx = hwdata[`CMD_IDX_BIT];
	assign err_clr = wr_fire && wr_addr_r == `OFS_FLAGS && hwdata[`FLG_ERR_BIT];
	assign irq_clr = (wr_fire && wr_addr_r == `OFS_IRQ_CLR) ? hwdata[`IRQ_BITS-1:0] : '0;

	// one pulse per kind of execution, only do_off while enable is off
	always_comb begin
		do_add    = 1'b0;
		do_sub    = 1'b0;
		do_mul    = 1'b0;
		do_clrc   = 1'b0;
		do_bad    = 1'b0;
		div_zero  = 1'b0;
		div_sat   = 1'b0;
		div_start = 1'b0;
		div_dvd   = {{DW{1'b0}}, opa_r};
		do_off    = cmd_go & ~cmd_en; // RL16
		if (cmd_go && cmd_en) begin
			unique case (cmd_op)
				`OP_ADC:   do_add = 1'b1;
				`OP_SBB:   do_sub = 1'b1;
				`OP_MUL:   do_mul = 1'b1;
				`OP_CLRC:  do_clrc = 1'b1;
				`OP_DIV16: begin
					div_zero  = opb_r == '0; // RL11
					div_start = opb_r != '0; // RL10
				end
				`OP_DIV32: begin
					div_dvd   = {opa_hi_r, opa_r}; // RL14
					div_zero  = opb_r == '0; // RL11
					div_sat   = opb_r != '0 && opa_hi_r >= opb_r; // RL15
					div_start = opb_r != '0 && opa_hi_r < opb_r; // RL14
				end
				default:   do_bad = 1'b1;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// datapath

	carry_adder #(
		.W(DW)
	) u_adder (
		.a   (opa_r),
		.b   (opb_r),
		.cin (carry_flag), // RL1 RL5
		.sub (cmd_op == `OP_SBB),
		.sum (as_sum),
		.cout(as_cout),
		.ovf (as_ovf)
	);

	assign product = {{DW{1'b0}}, opa_r} * {{DW{1'b0}}, opb_r}; // RL8

	serial_divider #(
		.W(DW)
	) u_div (
		.mclk    (mclk),
		.rst     (rst),
		.start   (div_start),
		.dividend(div_dvd),
		.divisor (opb_r),
		.done    (dv_done),
		.quot    (dv_quot),
		.rem     (dv_rem)
	);

	////////////////////////////////////////////////////////////////////////////
	// software operand and command registers

	// operand registers, refused while a divide runs
	always_ff @(posedge mclk) begin
		if (rst) begin
			opa_r    <= '0;
			opa_hi_r <= '0;
			opb_r    <= '0;
		end else if (wr_fire && state_r == st_idle) begin
			if (wr_addr_r == `OFS_OPA) opa_r <= hwdata[DW-1:0];
			if (wr_addr_r == `OFS_OPA_HI) opa_hi_r <= hwdata[DW-1:0];
			if (wr_addr_r == `OFS_OPB) opb_r <= hwdata[DW-1:0];
		end
	end

	// last accepted command, read back for software
	always_ff @(posedge mclk) begin
		if (rst) begin
			cmd_r <= '0;
			idx_r <= 1'b0;
		end else if (cmd_go) begin
			cmd_r <= hwdata[7:0];
			idx_r <= cmd_idx;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// results and flags

	// destination pair: base gets low word, next gets high word
	always_ff @(posedge mclk) begin
		if (rst) begin
			res_lo_r <= '0;
			res_hi_r <= '0;
		end else if (do_add || do_sub) begin
			res_lo_r <= as_sum; // RL1 RL5 RL4
		end else if (do_mul) begin
			res_lo_r <= product[DW-1:0]; // RL9
			res_hi_r <= product[2*DW-1:DW]; // RL9
		end else if (div_sat) begin
			res_lo_r <= '1; // RL15
			res_hi_r <= '0; // RL15
		end else if (dv_done) begin
			res_lo_r <= dv_quot; // RL10 RL14
			if (!idx_r) res_hi_r <= dv_rem; // RL13
		end
	end

	// shared carry flag, unchanged by every other operation
	always_ff @(posedge mclk) begin
		if (rst) begin
			carry_flag <= 1'b0;
		end else if (do_add || do_sub) begin
			carry_flag <= as_cout; // RL2 RL6 RL4
		end else if (do_clrc) begin
			carry_flag <= 1'b0; // RL7
		end
	end

	// sticky error flag, a new error wins over a software clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			instr_error_flag <= 1'b0;
		end else if (div_zero || div_sat) begin
			instr_error_flag <= 1'b1; // RL11 RL15
		end else if (err_clr) begin
			instr_error_flag <= 1'b0; // RL12
		end
	end

	// instruction output bit
	always_ff @(posedge mclk) begin
		if (rst) begin
			out_r <= 1'b0;
		end else if (do_off || do_bad || div_zero) begin
			out_r <= 1'b0; // RL16 RL11
		end else if (do_add || do_sub) begin
			out_r <= as_ovf; // RL3
		end else if (do_mul || do_clrc || div_sat || dv_done) begin
			out_r <= 1'b1; // RL8 RL10 RL15
		end
	end

	// divide sequencing
	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r <= st_idle;
		end else begin
			unique case (state_r)
				st_idle: if (div_start) state_r <= st_div;
				st_div:  if (dv_done) state_r <= st_idle;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupts

	always_comb begin
		ev                = '0;
		ev[`IRQ_DONE_BIT] = (cmd_go && !div_start) || dv_done;
		ev[`IRQ_ERR_BIT]  = div_zero | div_sat;
		ev[`IRQ_OVF_BIT]  = (do_add | do_sub) & as_ovf;
	end

	// sticky status, set wins over clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | ev;
		end
	end

	// enable mask
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_en_r <= '0;
		end else if (wr_fire && wr_addr_r == `OFS_IRQ_EN) begin
			irq_en_r <= hwdata[`IRQ_BITS-1:0];
		end
	end

	// level interrupt, one cycle behind the status
	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_en_r);
		end
	end

	assign hreadyout = hreadyout_r;
	assign hresp     = hresp_r;
	assign hrdata    = hrdata_r;
	assign irq       = irq_r;
endmodule

/* File: rtl/serial_divider.sv */
`include "arith_cfg.svh"

// restoring divider, one quotient bit per cycle; caller guarantees hi < divisor
module serial_divider
	import arith_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic           mclk,
	input  wire logic           rst,
	input  wire logic           start,
	input  wire logic [2*W-1:0] dividend,
	input  wire logic [W-1:0]   divisor,
	output logic                done,
	output logic      [W-1:0]   quot,
	output logic      [W-1:0]   rem
);
	localparam int CW = $clog2(W + 1);

	logic [W:0]    rem_r;
	logic [W-1:0]  quo_r;
	logic [W-1:0]  dsr_r;
	logic [CW-1:0] cnt_r;
	logic          done_r;
	logic [W:0]    trial;
	logic          fits;

	// shift in next dividend bit and try the subtraction
	always_comb begin
		trial = {rem_r[W-1:0], quo_r[W-1]};
		fits  = trial >= {1'b0, dsr_r};
	end

	// iteration registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			rem_r  <= '0;
			quo_r  <= '0;
			dsr_r  <= '0;
			cnt_r  <= '0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (start) begin
				rem_r <= {1'b0, dividend[2*W-1:W]};
				quo_r <= dividend[W-1:0];
				dsr_r <= divisor;
				cnt_r <= CW'(W);
			end else if (cnt_r != '0) begin
				rem_r  <= fits ? trial - {1'b0, dsr_r} : trial;
				quo_r  <= {quo_r[W-2:0], fits};
				cnt_r  <= cnt_r - 1'b1;
				done_r <= cnt_r == CW'(1);
			end
		end
	end

	assign done = done_r;
	assign quot = quo_r;
	assign rem  = rem_r[W-1:0];
endmodule

/* File: testbench/ahb_host.sv */
module ahb_host (
	input  wire logic        mclk,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	output logic             hsel,
	output logic [31:0]      haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata
);
	timeunit 1ns;
	timeprecision 1ps;

	// bus idle at time zero
	initial begin
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
	end

	// single word transfer; entered just after a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'b10;
		do @(posedge mclk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= w ? d : ~hwdata; // unused data bus keeps toggling
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule

/* File: testbench/arith_sva.sv */
module arith_sva
	import arith_pkg::*;
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	logic        wp_r;
	logic [7:0]  wa_r;
	logic [15:0] opb_r;
	logic        ok_r;
	logic        out_r;
	logic        cz_r;
	logic        err_r;
	logic        aph;
	logic        wcmd;
	logic        rflg;
	logic        zdiv;
	logic [2:0]  op;

	////////////////////////////////////////////////////////////////////////////////
	// bus phase decode
	assign aph = hsel & hready & htrans[1];
	assign wcmd = wp_r && wa_r == 8'h0c;
	assign rflg = aph && !hwrite && haddr[7:0] == 8'h18;
	assign op = hwdata[2:0];
	assign zdiv = hwdata[3] && op inside {3'h3, 3'h4} && opb_r == 16'h0000;

	// write data phase tracking
	always_ff @(posedge mclk) begin
		if (rst) begin
			wp_r <= 1'b0;
			wa_r <= 8'h00;
			opb_r <= 16'h0000;
		end else begin
			wp_r <= aph & hwrite;
			wa_r <= haddr[7:0];
			if (wp_r && wa_r == 8'h08)
				opb_r <= hwdata[15:0];
		end
	end

	// flag bits that follow from the commands written and the error clear
	always_ff @(posedge mclk) begin
		if (rst) begin
			ok_r <= 1'b0;
			out_r <= 1'b0;
			cz_r <= 1'b0;
			err_r <= 1'b0;
		end else if (wcmd) begin
			ok_r <= !hwdata[3] || op == 3'h2 || op >= 3'h5 || zdiv;
			out_r <= hwdata[3] && (op == 3'h2 || op == 3'h5);
			cz_r <= hwdata[3] ? op == 3'h5 : cz_r;
			if (zdiv)
				err_r <= 1'b1;
		end else if (wp_r && wa_r == 8'h18 && hwdata[1])
			err_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	a_ready_high: assert property (hreadyout)
		else $error("wait state seen");
	a_resp_okay: assert property (!hresp)
		else $error("error response seen");
	a_out_known: assert property (rflg && ok_r |=> hrdata[2] == $past(out_r))
		else $error("instruction out wrong");
	a_carry_clear: assert property (rflg && cz_r |=> !hrdata[0])
		else $error("carry not clear");
	a_error_sticky: assert property (rflg && err_r |=> hrdata[1])
		else $error("error flag lost");
	a_flags_narrow: assert property (rflg |=> hrdata[31:4] == 28'h0)
		else $error("flags upper bits set");
	a_unmapped_zero: assert property (aph && !hwrite && haddr[7:0] > 8'h24 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_irq_masked: assert property (wp_r && wa_r == 8'h24 && op == 3'h0 |-> ##2 !irq)
		else $error("irq high while masked");

	c_divide: cover property (wcmd && hwdata[3] && op == 3'h3);
	c_error_seen: cover property (rflg ##1 hrdata[1]);
	c_irq_high: cover property (irq);
endmodule

bind carry_arith_unit arith_sva i_sva (
	.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq)
);

/* File: testbench/testbench.sv */
module testbench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk;
	logic        rst;
	logic        hrdy;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hresp;
	logic [31:0] hrdata;
	logic        irq;
	logic [31:0] q;
	int          num_errors = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [7:0]  zaddr[8] = '{8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h40};

	carry_arith_unit #(.DW(16)) i_dut (
		.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hrdy),
		.hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .irq(irq)
	);

	ahb_host i_host (
		.mclk(mclk), .hready(hrdy), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		i_host.xfer(1'b0, a, 32'h0, q);
		cmp(q, e);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_host.xfer(1'b1, a, d, q);
	endtask

	// load operands, issue a command, poll out a divide
	task automatic run(input logic [15:0] a, input logic [15:0] b, input logic [7:0] c);
		int n;
		wr(8'h00, {16'h0, a});
		wr(8'h08, {16'h0, b});
		wr(8'h0c, {24'h0, c});
		n = 0;
		do begin
			i_host.xfer(1'b0, 8'h18, 32'h0, q);
			n++;
		end while (q[3] !== 1'b0 && n < 40);
		cmp({31'h0, q[3]}, 32'h0);
	endtask

	// destination word and flags nibble {busy, out, error, carry}
	task automatic res(input logic [15:0] lo, input logic [3:0] f);
		chk(8'h10, {16'h0, lo});
		chk(8'h18, {28'h0, f});
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// clock and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done();
		end
	end

	// main sequence
	initial begin
		rst = 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		foreach (zaddr[i]) chk(zaddr[i], 32'h0);
		wr(8'h0c, 32'h0d);
		chk(8'h18, 32'h4);
		wr(8'h0c, 32'h0e);
		chk(8'h18, 32'h0);
		chk(8'h0c, 32'h0e);
		run(16'h614e, 16'hd432, 8'h08);
		res(16'h3580, 4'h1);
		run(16'h00bc, 16'h0000, 8'h08);
		res(16'h00bd, 4'h0);
		wr(8'h0c, 32'h0d);
		run(16'h7fff, 16'h0001, 8'h08);
		res(16'h8000, 4'h4);
		wr(8'h0c, 32'h0d);
		run(16'h614e, 16'h4b20, 8'h09);
		res(16'h162e, 4'h0);
		run(16'h00bc, 16'h00bc, 8'h09);
		res(16'h0000, 4'h0);
		run(16'h0000, 16'h0001, 8'h09);
		res(16'hffff, 4'h1);
		run(16'h8000, 16'h0000, 8'h09);
		res(16'h7fff, 4'h4);
		run(16'hcd14, 16'h001e, 8'h0a);
		res(16'h0858, 4'h4);
		chk(8'h14, 32'h0018);
		run(16'hffff, 16'hffff, 8'h0a);
		res(16'h0001, 4'h4);
		chk(8'h14, 32'hfffe);
		run(16'hd431, 16'h012c, 8'h0b);
		res(16'h00b5, 4'h4);
		chk(8'h14, 32'h0015);
		run(16'h0b4e, 16'h0145, 8'h1b);
		res(16'h0008, 4'h4);
		chk(8'h14, 32'h0015);
		run(16'h0005, 16'h0000, 8'h0b);
		res(16'h0008, 4'h2);
		chk(8'h14, 32'h0015);
		run(16'h0002, 16'h0003, 8'h0a);
		res(16'h0006, 4'h6);
		wr(8'h18, 32'h2);
		chk(8'h18, 32'h4);
		wr(8'h04, 32'h5);
		run(16'h11e1, 16'h0fa0, 8'h0c);
		res(16'h0053, 4'h4);
		chk(8'h14, 32'h0101);
		wr(8'h04, 32'h10);
		run(16'h0000, 16'h0010, 8'h0c);
		res(16'hffff, 4'h6);
		chk(8'h14, 32'h0000);
		run(16'h1234, 16'h1234, 8'h00);
		res(16'hffff, 4'h2);
		// interrupt raise, mask and clear
		chk(8'h1c, 32'h7);
		wr(8'h24, 32'h2);
		chk(8'h24, 32'h2);
		cmp({31'h0, irq}, 32'h1);
		wr(8'h24, 32'h0);
		chk(8'h24, 32'h0);
		cmp({31'h0, irq}, 32'h0);
		wr(8'h20, 32'h7);
		chk(8'h1c, 32'h0);
		wr(8'h24, 32'h1);
		wr(8'h0c, 32'h0d);
		chk(8'h20, 32'h0);
		cmp({31'h0, irq}, 32'h1);
		test_done();
	end
endmodule
